// ===== pst_timers.sv
`timescale 1ns/100ps
// Behaviour
// - Four timers each drive their own output from their selected trigger per their mode.
// - The selected trigger starts the timer, and the default selection is off with no trigger.
// - Mode codes are 0 off, 1 delay, 2 alternate and 3 on-time, and reset selects delay.
// - In delay mode the output rises only once the delay time has elapsed after the trigger.
// - In delay mode the output falls at once when the trigger goes low.
// - In alternate mode while triggered the output cycles high for on-time and low for off-time.
// - In alternate mode the output is forced low as soon as the trigger goes away.
// - In on-time mode the output stays high for at least the on-time, beyond a short trigger.
// - The delay time runs from zero to 9:59:59.9 in tenths of a second, default zero.
// - On-time serves alternate and on-time modes, off-time serves alternate, same range.
// - Each timer's running value can be read back by software.
// - One set of running counters is shared by all parameter sets and survives a set switch.
// - Each timer output is offered to relays, logic inputs and virtual connections.
module pst_timers #(
	parameter int TICK_CYCLES = pst_pkg::PST_TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [63:0] trigger_sources,
	output logic timer_one_output,
	output logic timer_two_output,
	output logic timer_three_output,
	output logic timer_four_output
);
	localparam int NT = pst_pkg::PST_NUM_TIMERS;
	localparam int NCFG = pst_pkg::PST_NUM_TIMERS * pst_pkg::PST_NUM_SETS;

	// ==========================================================
	// Decoding helpers
	function automatic logic cfg_hit(input logic [11:0] addr);
		cfg_hit = addr[pst_pkg::PST_CFG_TOP:pst_pkg::PST_CFG_IDX_MSB + 1] == 2'h0 &&
			!addr[pst_pkg::PST_CFG_GAP] &&
			addr[pst_pkg::PST_FLD_MSB:pst_pkg::PST_FLD_LSB] <= pst_pkg::PST_FLD_OFF;
	endfunction

	function automatic logic value_hit(input logic [11:0] addr);
		value_hit = (addr & pst_pkg::PST_REG_VALUE_MASK) == pst_pkg::PST_REG_VALUE_BASE;
	endfunction

	function automatic logic [11:0] word_addr(input logic [11:0] addr);
		word_addr = {addr[11:2], 2'h0};
	endfunction

	function automatic pst_pkg::pst_time_t clamp_time(input logic [31:0] data);
		if (data > {13'h0000, pst_pkg::PST_TIME_MAX}) begin
			clamp_time = pst_pkg::PST_TIME_MAX;
		end else begin
			clamp_time = data[pst_pkg::PST_TIME_W-1:0];
		end
	endfunction

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// ==========================================================
	// Settings, one copy per parameter set
	pst_pkg::pst_mode_t mode_mem [NCFG];
	pst_pkg::pst_sel_t trig_mem [NCFG];
	pst_pkg::pst_time_t delay_mem [NCFG];
	pst_pkg::pst_time_t on_mem [NCFG];
	pst_pkg::pst_time_t off_mem [NCFG];
	logic [1:0] active_set;

	// ==========================================================
	// Time base
	logic [pst_pkg::PST_TICK_CNT_W-1:0] tick_cnt;
	logic tick;
	wire tick_wrap = tick_cnt == pst_pkg::PST_TICK_CNT_W'(TICK_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
			tick <= tick_wrap;
		end
	end

	// ==========================================================
	// Timer instances
	logic [NT-1:0] timer_out;
	logic [NT-1:0] timer_trig;
	pst_pkg::pst_time_t timer_value [NT];

	for (genvar i = 0; i < NT; i++) begin : g_timer
		pst_timer_if tif ();
		wire [3:0] cfg_idx = {active_set, 2'(i)};
		wire pst_pkg::pst_sel_t sel = trig_mem[cfg_idx];
		assign timer_trig[i] = sel != pst_pkg::PST_SEL_OFF && trigger_sources[sel];
		assign tif.trig = timer_trig[i];
		assign tif.tick = tick;
		assign tif.mode = mode_mem[cfg_idx];
		assign tif.delay = delay_mem[cfg_idx];
		assign tif.on_time = on_mem[cfg_idx];
		assign tif.off_time = off_mem[cfg_idx];
		assign timer_out[i] = tif.out;
		assign timer_value[i] = tif.value;
		pst_timer_unit u_unit (
			.aclk(aclk),
			.aresetn(aresetn),
			.tif(tif.unit)
		);
		AST_TRIG_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
			sel == pst_pkg::PST_SEL_OFF |-> !timer_trig[i])
			else $error("trigger seen with selection off");
	end

	assign timer_one_output = timer_out[0];
	assign timer_two_output = timer_out[1];
	assign timer_three_output = timer_out[2];
	assign timer_four_output = timer_out[3];

	// ==========================================================
	// Register read decode
	function automatic logic [31:0] rd_word(input logic [11:0] addr);
		logic [3:0] idx;
		logic [31:0] data;
		idx = addr[pst_pkg::PST_CFG_IDX_MSB:pst_pkg::PST_CFG_IDX_LSB];
		data = 32'h0000_0000;
		if (cfg_hit(addr)) begin
			case (addr[pst_pkg::PST_FLD_MSB:pst_pkg::PST_FLD_LSB])
				pst_pkg::PST_FLD_MODE: data = {30'h0000_0000, mode_mem[idx]};
				pst_pkg::PST_FLD_TRIG: data = {26'h000_0000, trig_mem[idx]};
				pst_pkg::PST_FLD_DELAY: data = {13'h0000, delay_mem[idx]};
				pst_pkg::PST_FLD_ON: data = {13'h0000, on_mem[idx]};
				pst_pkg::PST_FLD_OFF: data = {13'h0000, off_mem[idx]};
				default: data = 32'h0000_0000;
			endcase
		end else if (value_hit(addr)) begin
			data = {13'h0000,
				timer_value[addr[pst_pkg::PST_VAL_IDX_MSB:pst_pkg::PST_VAL_IDX_LSB]]};
		end else if (word_addr(addr) == pst_pkg::PST_REG_ACTIVE_SET) begin
			data = {30'h0000_0000, active_set};
		end else if (word_addr(addr) == pst_pkg::PST_REG_OUT_STATUS) begin
			data = {28'h000_0000, timer_out};
		end else if (word_addr(addr) == pst_pkg::PST_REG_TRIG_STATUS) begin
			data = {28'h000_0000, timer_trig};
		end
		rd_word = data;
	endfunction

	function automatic logic rd_ok(input logic [11:0] addr);
		rd_ok = cfg_hit(addr) || value_hit(addr) ||
			word_addr(addr) == pst_pkg::PST_REG_ACTIVE_SET ||
			word_addr(addr) == pst_pkg::PST_REG_OUT_STATUS ||
			word_addr(addr) == pst_pkg::PST_REG_TRIG_STATUS;
	endfunction

	// ==========================================================
	// AXI4-Lite write channel
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_full;
	logic w_full;

	wire wr_fire = aw_full && w_full && !s_axi_bvalid;
	wire [31:0] wr_mask = strb_mask(w_strb_q);
	logic [31:0] wr_word;
	// Procedural, so a change in stored settings also refreshes the merge
	always_comb begin
		wr_word = (rd_word(aw_addr_q) & ~wr_mask) | (w_data_q & wr_mask);
	end
	wire wr_cfg = wr_fire && cfg_hit(aw_addr_q);
	wire wr_set = wr_fire && word_addr(aw_addr_q) == pst_pkg::PST_REG_ACTIVE_SET;
	wire wr_legal = cfg_hit(aw_addr_q) || word_addr(aw_addr_q) == pst_pkg::PST_REG_ACTIVE_SET;
	wire [3:0] wr_idx = aw_addr_q[pst_pkg::PST_CFG_IDX_MSB:pst_pkg::PST_CFG_IDX_LSB];
	wire [2:0] wr_fld = aw_addr_q[pst_pkg::PST_FLD_MSB:pst_pkg::PST_FLD_LSB];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pst_pkg::PST_RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_legal ? pst_pkg::PST_RESP_OKAY : pst_pkg::PST_RESP_SLVERR;
				aw_full <= 1'b0;
				w_full <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Settings storage; running values live in the units and are never touched here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_set <= 2'h0;
			for (int k = 0; k < NCFG; k++) begin
				mode_mem[k] <= pst_pkg::PST_MODE_RESET;
				trig_mem[k] <= pst_pkg::PST_SEL_OFF;
				delay_mem[k] <= pst_pkg::PST_TIME_RESET;
				on_mem[k] <= pst_pkg::PST_TIME_RESET;
				off_mem[k] <= pst_pkg::PST_TIME_RESET;
			end
		end else begin
			if (wr_set) begin
				active_set <= wr_word[1:0];
			end
			if (wr_cfg) begin
				case (wr_fld)
					pst_pkg::PST_FLD_MODE: mode_mem[wr_idx] <= wr_word[1:0];
					pst_pkg::PST_FLD_TRIG: trig_mem[wr_idx] <= wr_word[pst_pkg::PST_SEL_W-1:0];
					pst_pkg::PST_FLD_DELAY: delay_mem[wr_idx] <= clamp_time(wr_word);
					pst_pkg::PST_FLD_ON: on_mem[wr_idx] <= clamp_time(wr_word);
					pst_pkg::PST_FLD_OFF: off_mem[wr_idx] <= clamp_time(wr_word);
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= pst_pkg::PST_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word(s_axi_araddr);
				s_axi_rresp <= rd_ok(s_axi_araddr) ? pst_pkg::PST_RESP_OKAY :
					pst_pkg::PST_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks
	sequence pst_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence pst_wr_both;
		aw_full && w_full && !s_axi_bvalid;
	endsequence
	sequence pst_wr_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence pst_rd_done;
		s_axi_rvalid && s_axi_rready;
	endsequence

	AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		pst_rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered one cycle after address");
	AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		pst_wr_both |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response missing");
	AST_TICK_SINGLE: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick)
		else $error("tick held longer than one cycle");
	AST_TICK_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |-> tick_cnt == '0)
		else $error("tick out of step with its counter");
	AST_READ_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held until taken");
	AST_WRITE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held until taken");
	AST_WRITE_REOPEN: assert property (@(posedge aclk) disable iff (!aresetn)
		pst_wr_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channels not reopened after response");
	AST_READ_REOPEN: assert property (@(posedge aclk) disable iff (!aresetn)
		pst_rd_done |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened after data");
	AST_RO_REFUSED: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !wr_legal |=> s_axi_bresp == pst_pkg::PST_RESP_SLVERR)
		else $error("write to a read-only or unmapped word accepted");
	AST_UNMAPPED_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && !rd_ok(s_axi_araddr) |=>
			s_axi_rresp == pst_pkg::PST_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	AST_SET_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_set |=> active_set == $past(wr_word[1:0]))
		else $error("active parameter set not stored");
	AST_MODE_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_cfg && wr_fld == pst_pkg::PST_FLD_MODE |=>
			mode_mem[$past(wr_idx)] == $past(wr_word[1:0]))
		else $error("mode setting not stored");
	AST_TIME_CLAMP: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_cfg && wr_fld == pst_pkg::PST_FLD_DELAY |=>
			delay_mem[$past(wr_idx)] <= pst_pkg::PST_TIME_MAX)
		else $error("delay time stored beyond its range");
	AST_STATUS_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && word_addr(s_axi_araddr) == pst_pkg::PST_REG_OUT_STATUS
			|=> s_axi_rdata == {28'h000_0000, $past(timer_out)})
		else $error("output status read wrong");
endmodule

// ===== pst_pkg.sv
package pst_pkg;
	// ==========================================================
	// Time base
	localparam int PST_CLK_PERIOD_NS = 4;
	localparam int PST_TICK_PERIOD_NS = 100_000_000;
	localparam int PST_TICK_CYCLES = PST_TICK_PERIOD_NS / PST_CLK_PERIOD_NS;
	localparam int PST_TICK_CNT_W = 25;

	// ==========================================================
	// Timer settings
	localparam int PST_NUM_TIMERS = 4;
	localparam int PST_NUM_SETS = 4;
	localparam int PST_TIME_W = 19;
	localparam int PST_SEL_W = 6;
	localparam int PST_NUM_SOURCES = 64;
	typedef logic [PST_TIME_W-1:0] pst_time_t;
	typedef logic [1:0] pst_mode_t;
	typedef logic [PST_SEL_W-1:0] pst_sel_t;
	localparam pst_mode_t PST_MODE_OFF = 2'h0;
	localparam pst_mode_t PST_MODE_DELAY = 2'h1;
	localparam pst_mode_t PST_MODE_ALT = 2'h2;
	localparam pst_mode_t PST_MODE_ONTIME = 2'h3;
	localparam pst_mode_t PST_MODE_RESET = PST_MODE_DELAY;
	localparam pst_sel_t PST_SEL_OFF = 6'h00;
	localparam pst_time_t PST_TIME_RESET = 19'h0_0000;
	localparam pst_time_t PST_TIME_MAX = 19'h5_7E3F;
	localparam pst_time_t PST_TIME_ONE = 19'h0_0001;

	// ==========================================================
	// Register map, byte addresses
	localparam int PST_ADDR_W = 12;
	localparam logic [11:0] PST_REG_ACTIVE_SET = 12'h400;
	localparam logic [11:0] PST_REG_VALUE_BASE = 12'h410;
	localparam logic [11:0] PST_REG_VALUE_MASK = 12'hFF0;
	localparam logic [11:0] PST_REG_OUT_STATUS = 12'h420;
	localparam logic [11:0] PST_REG_TRIG_STATUS = 12'h424;
	localparam int PST_CFG_TOP = 11;
	localparam int PST_CFG_IDX_MSB = 9;
	localparam int PST_CFG_IDX_LSB = 6;
	localparam int PST_CFG_GAP = 5;
	localparam int PST_FLD_MSB = 4;
	localparam int PST_FLD_LSB = 2;
	localparam int PST_VAL_IDX_MSB = 3;
	localparam int PST_VAL_IDX_LSB = 2;
	localparam logic [2:0] PST_FLD_MODE = 3'h0;
	localparam logic [2:0] PST_FLD_TRIG = 3'h1;
	localparam logic [2:0] PST_FLD_DELAY = 3'h2;
	localparam logic [2:0] PST_FLD_ON = 3'h3;
	localparam logic [2:0] PST_FLD_OFF = 3'h4;
	localparam logic [1:0] PST_RESP_OKAY = 2'h0;
	localparam logic [1:0] PST_RESP_SLVERR = 2'h2;
endpackage

// ===== pst_timer_if.sv
`timescale 1ns/100ps
interface pst_timer_if;
	pst_pkg::pst_mode_t mode;
	logic trig;
	logic tick;
	pst_pkg::pst_time_t delay;
	pst_pkg::pst_time_t on_time;
	pst_pkg::pst_time_t off_time;
	logic out;
	pst_pkg::pst_time_t value;
	modport unit (
		input mode,
		input trig,
		input tick,
		input delay,
		input on_time,
		input off_time,
		output out,
		output value
	);
	modport ctrl (
		output mode,
		output trig,
		output tick,
		output delay,
		output on_time,
		output off_time,
		input out,
		input value
	);
endinterface

// ===== pst_timer_unit.sv
`timescale 1ns/100ps
module pst_timer_unit (
	input wire logic aclk,
	input wire logic aresetn,
	pst_timer_if.unit tif
);
	typedef enum logic {PST_PH_ON, PST_PH_OFF} pst_phase_t;

	logic out;
	pst_pkg::pst_time_t value;
	pst_phase_t phase;
	logic trig_q;
	logic next_out;
	pst_pkg::pst_time_t next_value;
	pst_phase_t next_phase;
	pst_pkg::pst_time_t value_inc;
	logic trig_rise;

	// ==========================================================
	// Counting in tenths, saturating at the top of the range
	assign value_inc = (tif.tick && value < pst_pkg::PST_TIME_MAX) ?
		value + pst_pkg::PST_TIME_ONE : value;
	assign trig_rise = tif.trig && !trig_q;

	always_comb begin
		next_out = out;
		next_value = value;
		next_phase = phase;
		case (tif.mode)
			pst_pkg::PST_MODE_OFF: begin
				next_out = 1'b0;
				next_value = pst_pkg::PST_TIME_RESET;
				next_phase = PST_PH_ON;
			end
			pst_pkg::PST_MODE_DELAY: begin
				if (!tif.trig) begin
					next_out = 1'b0;
					next_value = pst_pkg::PST_TIME_RESET;
				end else if (value >= tif.delay) begin
					next_out = 1'b1;
				end else begin
					next_out = 1'b0;
					next_value = value_inc;
				end
			end
			pst_pkg::PST_MODE_ALT: begin
				if (!tif.trig) begin
					next_out = 1'b0;
					next_value = pst_pkg::PST_TIME_RESET;
					next_phase = PST_PH_ON;
				end else if (trig_rise) begin
					next_out = 1'b1;
					next_value = pst_pkg::PST_TIME_RESET;
					next_phase = PST_PH_ON;
				end else begin
					case (phase)
						PST_PH_ON: begin
							if (value >= tif.on_time) begin
								next_out = 1'b0;
								next_value = pst_pkg::PST_TIME_RESET;
								next_phase = PST_PH_OFF;
							end else begin
								next_out = 1'b1;
								next_value = value_inc;
							end
						end
						PST_PH_OFF: begin
							if (value >= tif.off_time) begin
								next_out = 1'b1;
								next_value = pst_pkg::PST_TIME_RESET;
								next_phase = PST_PH_ON;
							end else begin
								next_out = 1'b0;
								next_value = value_inc;
							end
						end
						default: begin
							next_phase = PST_PH_ON;
						end
					endcase
				end
			end
			pst_pkg::PST_MODE_ONTIME: begin
				if (trig_rise) begin
					next_out = 1'b1;
					next_value = pst_pkg::PST_TIME_RESET;
				end else if (tif.trig) begin
					next_out = 1'b1;
					next_value = value_inc;
				end else if (out && value < tif.on_time) begin
					next_value = value_inc;
				end else begin
					next_out = 1'b0;
				end
			end
			default: begin
				next_out = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out <= 1'b0;
			value <= pst_pkg::PST_TIME_RESET;
			phase <= PST_PH_ON;
			trig_q <= 1'b0;
		end else begin
			out <= next_out;
			value <= next_value;
			phase <= next_phase;
			trig_q <= tif.trig;
		end
	end

	assign tif.out = out;
	assign tif.value = value;

	// ==========================================================
	// Checks
	sequence pst_alt_start;
		tif.mode == pst_pkg::PST_MODE_ALT && tif.trig && !trig_q;
	endsequence
	sequence pst_alt_started;
		out && value == pst_pkg::PST_TIME_RESET;
	endsequence

	AST_OFF_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.mode == pst_pkg::PST_MODE_OFF |=> !out && value == pst_pkg::PST_TIME_RESET)
		else $error("timer not quiet while off");
	AST_DELAY_EARLY: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.mode == pst_pkg::PST_MODE_DELAY && value < tif.delay |=> !out)
		else $error("delay output rose before the delay elapsed");
	AST_DELAY_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.mode == pst_pkg::PST_MODE_DELAY && !tif.trig |=> !out)
		else $error("delay output did not follow trigger low");
	AST_ALT_START: assert property (@(posedge aclk) disable iff (!aresetn)
		pst_alt_start |=> pst_alt_started)
		else $error("alternate cycle did not start high");
	AST_ALT_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.mode == pst_pkg::PST_MODE_ALT && !tif.trig |=> !out)
		else $error("alternate output not forced low");
	AST_ONTIME_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.mode == pst_pkg::PST_MODE_ONTIME && tif.trig |=> out)
		else $error("on-time output low while triggered");
	AST_VALUE_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
		!tif.tick |=> value == $past(value) || value == pst_pkg::PST_TIME_RESET)
		else $error("timer value moved without a tick");
endmodule

// ===== pst_source_model.sv
`timescale 1ns/100ps
// ==========================================================
// Far side: signal sources feeding the trigger selectors
module pst_source_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] fire,
	input wire logic [3:0] timer_outs,
	output logic [63:0] trigger_sources
);
	logic [63:0] chatter;
	// Unselected sources toggle every cycle so a wrong select shows up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chatter <= 64'h0000_0000_0000_0000;
		end else begin
			chatter <= ~chatter;
		end
	end
	// Sources 5..8 are the bench's triggers, 9 is timer one fed back
	assign trigger_sources = {chatter[63:10], timer_outs[0], fire, chatter[4:0]};
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] fire = 4'h0;
	wire awr, wrd, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [63:0] src;
	wire [3:0] outs;
	int n_fail = 0;
	int compares = 0;
	logic [31:0] v, v0;
	logic [1:0] rs;

	pst_timers #(.TICK_CYCLES(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.trigger_sources(src), .timer_one_output(outs[0]), .timer_two_output(outs[1]),
		.timer_three_output(outs[2]), .timer_four_output(outs[3]));
	pst_source_model i_src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
		.timer_outs(outs), .trigger_sources(src));

	always #2 aclk = ~aclk;

	// ==========================================================
	// Compare, bus and wait tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", nm, e, s);
		end
	endtask
	function automatic logic [11:0] cfg(input logic [1:0] s, input logic [1:0] t,
		input logic [2:0] f);
		return {2'h0, s, t, 1'b0, f, 2'h0};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awv && awr) begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wrd) begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge aclk); while (bv !== 1'b1);
		rs = br;
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge aclk); while (rv !== 1'b1);
		v = rdat;
		rs = rr;
		rry <= 1'b0;
	endtask
	task automatic wait_out(input int i, input logic e, input int lim);
		int n;
		n = 0;
		while (outs[i] !== e && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk1("timer output", e, outs[i]);
	endtask
	task automatic close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		$display("ERROR watchdog expected finish seen timeout");
		close_out;
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_MODE));
		chk("mode reset", 32'(pst_pkg::PST_MODE_RESET), v);
		rd(cfg(2'h3, 2'h3, pst_pkg::PST_FLD_TRIG));
		chk("select reset", 32'(pst_pkg::PST_SEL_OFF), v);
		rd(cfg(2'h1, 2'h2, pst_pkg::PST_FLD_DELAY));
		chk("delay reset", 32'h0000_0000, v);
		rd(cfg(2'h2, 2'h1, pst_pkg::PST_FLD_ON));
		chk("on reset", 32'h0000_0000, v);
		rd(cfg(2'h0, 2'h2, pst_pkg::PST_FLD_OFF));
		chk("off reset", 32'h0000_0000, v);
		rd(pst_pkg::PST_REG_ACTIVE_SET);
		chk("set reset", 32'h0000_0000, v);
		chk("outputs idle", 32'h0000_0000, 32'(outs));
		rd(12'h430);
		chk("unmapped resp", 32'(pst_pkg::PST_RESP_SLVERR), 32'(rs));
		wr(pst_pkg::PST_REG_VALUE_BASE, 32'h0000_0005);
		chk("ro write resp", 32'(pst_pkg::PST_RESP_SLVERR), 32'(rs));
		wr(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_DELAY), 32'h000F_FFFF);
		chk("write resp", 32'(pst_pkg::PST_RESP_OKAY), 32'(rs));
		rd(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_DELAY));
		chk("delay clamp", 32'(pst_pkg::PST_TIME_MAX), v);
		// Mode off ignores the trigger
		wr(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_TRIG), 32'h0000_0005);
		wr(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_MODE), 32'(pst_pkg::PST_MODE_OFF));
		fire[0] <= 1'b1;
		repeat (12) @(posedge aclk);
		chk1("off output", 1'b0, outs[0]);
		rd(pst_pkg::PST_REG_VALUE_BASE);
		chk("off value", 32'h0000_0000, v);
		fire[0] <= 1'b0;
		// Delay mode, with timer four chained to timer one
		wr(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_MODE), 32'(pst_pkg::PST_MODE_DELAY));
		wr(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_DELAY), 32'h0000_0003);
		wr(cfg(2'h0, 2'h3, pst_pkg::PST_FLD_TRIG), 32'h0000_0009);
		fire[0] <= 1'b1;
		repeat (8) @(posedge aclk);
		chk1("delay early", 1'b0, outs[0]);
		wait_out(0, 1'b1, 12);
		wait_out(3, 1'b1, 3);
		rd(pst_pkg::PST_REG_OUT_STATUS);
		chk("out status", 32'h0000_0009, v);
		rd(pst_pkg::PST_REG_TRIG_STATUS);
		chk("trig status", 32'h0000_0009, v);
		fire[0] <= 1'b0;
		wait_out(0, 1'b0, 2);
		// Alternate mode on timer two
		wr(cfg(2'h0, 2'h1, pst_pkg::PST_FLD_TRIG), 32'h0000_0006);
		wr(cfg(2'h0, 2'h1, pst_pkg::PST_FLD_MODE), 32'(pst_pkg::PST_MODE_ALT));
		wr(cfg(2'h0, 2'h1, pst_pkg::PST_FLD_ON), 32'h0000_0002);
		wr(cfg(2'h0, 2'h1, pst_pkg::PST_FLD_OFF), 32'h0000_0002);
		fire[1] <= 1'b1;
		wait_out(1, 1'b1, 3);
		repeat (4) @(posedge aclk);
		chk1("alt on phase", 1'b1, outs[1]);
		wait_out(1, 1'b0, 14);
		wait_out(1, 1'b1, 14);
		fire[1] <= 1'b0;
		wait_out(1, 1'b0, 2);
		// On-time mode on timer three, one-cycle trigger
		wr(cfg(2'h0, 2'h2, pst_pkg::PST_FLD_TRIG), 32'h0000_0007);
		wr(cfg(2'h0, 2'h2, pst_pkg::PST_FLD_MODE), 32'(pst_pkg::PST_MODE_ONTIME));
		wr(cfg(2'h0, 2'h2, pst_pkg::PST_FLD_ON), 32'h0000_0003);
		@(posedge aclk);
		fire[2] <= 1'b1;
		@(posedge aclk);
		fire[2] <= 1'b0;
		wait_out(2, 1'b1, 3);
		repeat (4) @(posedge aclk);
		chk1("on-time held", 1'b1, outs[2]);
		wait_out(2, 1'b0, 16);
		// Set switch keeps the running value
		wr(cfg(2'h0, 2'h0, pst_pkg::PST_FLD_DELAY), 32'h0000_0032);
		wr(cfg(2'h1, 2'h0, pst_pkg::PST_FLD_TRIG), 32'h0000_0005);
		wr(cfg(2'h1, 2'h0, pst_pkg::PST_FLD_DELAY), 32'h0000_012C);
		fire[0] <= 1'b1;
		repeat (20) @(posedge aclk);
		rd(pst_pkg::PST_REG_VALUE_BASE);
		v0 = v;
		chk1("value running", 1'b1, v0 > 32'h0000_0000);
		wr(pst_pkg::PST_REG_ACTIVE_SET, 32'h0000_0001);
		rd(pst_pkg::PST_REG_VALUE_BASE);
		chk1("value kept", 1'b1, v >= v0);
		chk1("set one output", 1'b0, outs[0]);
		wr(cfg(2'h1, 2'h0, pst_pkg::PST_FLD_DELAY), 32'h0000_0002);
		wait_out(0, 1'b1, 3);
		fire[0] <= 1'b0;
		wait_out(0, 1'b0, 2);
		close_out;
	end
endmodule
